// *** rtl/dcr_defs.svh ***
`ifndef DCR_DEFS_SVH
`define DCR_DEFS_SVH

// Message identifiers in bits 30:26
`define DCR_ID_CONFIG 5'h08
`define DCR_ID_STATUS 5'h09
`define DCR_ID_CURRENT 5'h0a

// Frame length in bits
`define DCR_FRAME_BITS 6'h20

// Reset values
`define DCR_CONFIG_RESET 24'hffffff
`define DCR_LATCH_RESET 1'b1
`define DCR_CURRENT_RESET 14'h0000

// Retry interval in PWM periods per unit of the retry field
`define DCR_RETRY_MULT 6'h04
`define DCR_RETRY_ZERO_PERIODS 6'h01

`endif

// *** rtl/dcr_msg_core.sv ***
// Functional notes
// - Bits 30:26 carry the identifier, 01000 selects the configuration, bit 31 high writes and low reads.
// - Identifier 01001 is answered with the four-channel fault and test flag word.
// - Identifier 01010 reads the current of the channel in bits 25:24, and that number is echoed back.
// - For the status and current reads a set bit 31 is taken as a read and changes nothing.
// - Each channel holds a 2-bit battery short threshold at bits 23:22, 17:16, 11:10 and 5:4.
// - Each channel holds a 4-bit retry field and retries four times that many PWM periods after a fault.
// - A retry field of zero gives a retry interval of exactly one PWM period.
// - Reset sets all threshold and retry fields to ones, low 24 bits ffffff.
// - Ground short faults of channels 0 to 3 sit in status bits 25, 19, 13 and 7.
// - Gate-off test done flags sit in status bits 24, 18, 12 and 6.
// - Battery short faults sit in bits 23, 17, 11, 5 and their test done flags in 22, 16, 10, 4.
// - Open load gate-off faults sit in bits 21, 15, 9, 3 and gate-on faults in 20, 14, 8, 2.
// - Enable pin latch is bit 1 and reset pin latch bit 0, both set after reset.
// - The current read returns a 14-bit fraction of full scale in bits 13:0, zero after reset.
// - A falling enable pin keeps its latch set until the pin is high and a status read arrives.
`include "dcr_defs.svh"
`default_nettype none
module dcr_msg_core (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Serial link pins
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe_b,
  // Device pins and analog side
  input wire logic enable_pin,
  input wire dcr_pkg::dcr_diag_flags_t [3:0] diag_flags,
  input wire logic [3:0][13:0] current_value,
  // Retry timing
  input wire logic pwm_period_tick,
  input wire logic [3:0] retry_start,
  output logic [3:0] retry_expired,
  // Configuration towards the comparators
  output dcr_pkg::dcr_chan_cfg_t [3:0] chan_cfg
);

  // ********************************
  // Pin synchronisers
  // ********************************
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync3_reg;
  logic [3:0] filt_reg;
  logic [3:0] filt_prev_reg;
  logic [3:0] filt_next;

  // Change accepted only once second and third stage agree
  always_comb
  begin
    for (int k = 0; k < 4; k++)
      filt_next[k] = (sync2_reg[k] == sync3_reg[k]) ? sync3_reg[k] : filt_reg[k];
  end

  // Order: 0 sclk, 1 cs_b, 2 mosi, 3 enable
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_reg <= 4'h2;
      sync2_reg <= 4'h2;
      sync3_reg <= 4'h2;
      filt_reg <= 4'h2;
      filt_prev_reg <= 4'h2;
    end
    else
    begin
      sync1_reg <= {enable_pin, mosi, cs_b, sclk};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg <= filt_next;
      filt_prev_reg <= filt_reg;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic enable_fall;
  assign sclk_rise = filt_reg[0] & ~filt_prev_reg[0] & ~filt_reg[1];
  assign sclk_fall = ~filt_reg[0] & filt_prev_reg[0] & ~filt_reg[1];
  assign cs_fall = ~filt_reg[1] & filt_prev_reg[1];
  assign cs_rise = filt_reg[1] & ~filt_prev_reg[1];
  assign enable_fall = ~filt_reg[3] & filt_prev_reg[3];

  // ********************************
  // Frame shifter
  // ********************************
  logic [5:0] bit_cnt_reg;
  logic [31:0] rx_reg;
  logic [31:0] tx_reg;
  logic [31:0] resp_reg;
  logic frame_done;
  dcr_pkg::dcr_msg_t msg;
  assign msg = rx_reg;
  // Short or long frames are dropped whole, never half applied
  assign frame_done = cs_rise && (bit_cnt_reg == `DCR_FRAME_BITS);

  // Sample on rising sclk, count saturates past one frame
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bit_cnt_reg <= 6'h00;
      rx_reg <= 32'h00000000;
    end
    else if (cs_fall)
      bit_cnt_reg <= 6'h00;
    else if (sclk_rise)
    begin
      rx_reg <= {rx_reg[30:0], filt_reg[2]};
      if (bit_cnt_reg != 6'h3f)
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
    end
  end

  // Response to the previous frame goes out MSB first, shifted on falling sclk
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      tx_reg <= 32'h00000000;
    else if (cs_fall)
      tx_reg <= resp_reg;
    else if (sclk_fall && (bit_cnt_reg != 6'h00))
      tx_reg <= {tx_reg[30:0], 1'b0};
  end

  // Pin released while chip select is high
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      miso <= 1'b0;
      miso_oe_b <= 1'b1;
    end
    else
    begin
      miso <= tx_reg[31];
      miso_oe_b <= filt_reg[1];
    end
  end

  // ********************************
  // Message decode and registers
  // ********************************
  logic cfg_write;
  logic status_read;
  logic current_read;
  logic [23:0] cfg_reg;
  logic enable_latch_reg;
  logic reset_latch_reg;
  logic [31:0] resp_next;
  assign cfg_write = frame_done && msg.write && (msg.message_identifier == `DCR_ID_CONFIG);
  // Write bit ignored on the read-only messages
  assign status_read = frame_done && (msg.message_identifier == `DCR_ID_STATUS);
  assign current_read = frame_done && (msg.message_identifier == `DCR_ID_CURRENT);

  // Configuration word, all ones after reset
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      cfg_reg <= `DCR_CONFIG_RESET;
    else if (cfg_write)
      cfg_reg <= msg.payload;
  end

  // Comparator settings come straight from the stored word
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      chan_cfg <= `DCR_CONFIG_RESET;
    else
      chan_cfg <= cfg_reg;
  end

  // Set beats clear; enable clear needs the pin high again
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      enable_latch_reg <= `DCR_LATCH_RESET;
      reset_latch_reg <= `DCR_LATCH_RESET;
    end
    else
    begin
      if (enable_fall)
        enable_latch_reg <= 1'b1;
      else if (status_read && filt_reg[3])
        enable_latch_reg <= 1'b0;
      if (status_read)
        reset_latch_reg <= 1'b0;
    end
  end

  // Response builder; unknown identifiers answer all zero but the echo
  always_comb
  begin
    resp_next = 32'h00000000;
    resp_next[30:26] = msg.message_identifier;
    if (msg.message_identifier == `DCR_ID_CONFIG)
      resp_next[23:0] = cfg_write ? msg.payload : cfg_reg;
    else if (msg.message_identifier == `DCR_ID_STATUS)
      resp_next[25:0] = {diag_flags[0], diag_flags[1], diag_flags[2], diag_flags[3],
        enable_latch_reg, reset_latch_reg};
    else if (msg.message_identifier == `DCR_ID_CURRENT)
    begin
      resp_next[25:24] = {msg.channel_select_hi, msg.channel_select_lo};
      resp_next[13:0] = current_value[{msg.channel_select_hi, msg.channel_select_lo}];
    end
  end

  // Zero current reading until the first frame completes
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      resp_reg <= 32'h00000000;
    else if (frame_done)
      resp_reg <= resp_next;
  end

  // ********************************
  // Battery short retry timers
  // ********************************
  logic [3:0][5:0] retry_cnt_reg;
  logic [3:0] retry_armed_reg;
  for (genvar i = 0; i < 4; i++)
  begin : g_retry
    logic [3:0] field;
    logic [5:0] target;
    assign field = cfg_reg[6*(3-i) +: 4];
    // Zero would wrap and only fire after 64 periods, so it means one period
    assign target = (field == 4'h0) ? `DCR_RETRY_ZERO_PERIODS :
      6'(`DCR_RETRY_MULT * field);

    // Counts PWM periods down from the target
    always_ff @(posedge mclk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        retry_cnt_reg[i] <= 6'h00;
        retry_armed_reg[i] <= 1'b0;
        retry_expired[i] <= 1'b0;
      end
      else
      begin
        retry_expired[i] <= 1'b0;
        if (retry_start[i])
        begin
          retry_cnt_reg[i] <= target;
          retry_armed_reg[i] <= 1'b1;
        end
        else if (pwm_period_tick && retry_armed_reg[i])
        begin
          if (retry_cnt_reg[i] == 6'h01)
          begin
            retry_armed_reg[i] <= 1'b0;
            retry_expired[i] <= 1'b1;
          end
          retry_cnt_reg[i] <= retry_cnt_reg[i] - 6'h01;
        end
      end
    end

    a_retry_load: assert property (@(posedge mclk) disable iff (!rst_b)
      retry_start[i] |=> retry_cnt_reg[i] == ((field == 4'h0) ? 6'h01 : {field, 2'b00}))
      else $error("retry count loaded wrong");
  end

  // ********************************
  // Checks
  // ********************************
  a_cfg_write: assert property (@(posedge mclk) disable iff (!rst_b)
    cfg_write |=> cfg_reg == $past(msg.payload) ##1 chan_cfg == $past(cfg_reg))
    else $error("config write not stored");
  a_ro_stable: assert property (@(posedge mclk) disable iff (!rst_b)
    frame_done && (msg.message_identifier != `DCR_ID_CONFIG) |=> $stable(cfg_reg))
    else $error("read-only message changed config");
  a_status_word: assert property (@(posedge mclk) disable iff (!rst_b)
    status_read |=> resp_reg[25:2] == $past({diag_flags[0], diag_flags[1],
      diag_flags[2], diag_flags[3]}))
    else $error("status flags misplaced");
  a_current_echo: assert property (@(posedge mclk) disable iff (!rst_b)
    current_read |=> resp_reg[25:24] == $past(rx_reg[25:24])
      && resp_reg[23:14] == 10'h000 && resp_reg[13:0] == $past(current_value[rx_reg[25:24]]))
    else $error("current response wrong");
  a_resp_header: assert property (@(posedge mclk) disable iff (!rst_b)
    frame_done |=> !resp_reg[31] && resp_reg[30:26] == $past(rx_reg[30:26]))
    else $error("response header wrong");
  a_enable_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    enable_latch_reg && !(status_read && filt_reg[3]) |=> enable_latch_reg)
    else $error("enable latch dropped early");
  a_latch_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    status_read && filt_reg[3] && !enable_fall |=> !enable_latch_reg && !reset_latch_reg)
    else $error("latches not cleared by status read");
  a_miso_release: assert property (@(posedge mclk) disable iff (!rst_b)
    filt_reg[1] [*2] |=> miso_oe_b)
    else $error("miso driven outside frame");

  c_cfg_write: cover property (@(posedge mclk) disable iff (!rst_b) cfg_write);
  c_status_read: cover property (@(posedge mclk) disable iff (!rst_b)
    status_read && enable_latch_reg);
  c_current_read: cover property (@(posedge mclk) disable iff (!rst_b)
    current_read && msg.write);
  c_retry_done: cover property (@(posedge mclk) disable iff (!rst_b) retry_expired[0]);

endmodule
`default_nettype wire

// *** rtl/dcr_pkg.sv ***
`default_nettype none
package dcr_pkg;

  // Per-channel diagnostic flags, packed in response bit order
  typedef struct packed {
    logic ground_short_fault;
    logic gate_off_test_done;
    logic battery_short_fault;
    logic battery_short_test_done;
    logic open_load_gate_off_fault;
    logic open_load_gate_on_fault;
  } dcr_diag_flags_t;

  // Per-channel configuration, packed in message bit order
  typedef struct packed {
    logic [1:0] battery_short_threshold;
    logic [3:0] battery_short_retry;
  } dcr_chan_cfg_t;

  // One 32-bit message as it travels on the link
  typedef struct packed {
    logic write;
    logic [4:0] message_identifier;
    logic channel_select_hi;
    logic channel_select_lo;
    logic [23:0] payload;
  } dcr_msg_t;

endpackage
`default_nettype wire

// *** testbench/dcr_spi_host.sv ***
`default_nettype none
// ********
// Host side of the message link
// ********
module dcr_spi_host (
  // Clock
  input wire logic mclk,
  // Link pins
  output logic sclk,
  output logic cs_b,
  output logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle link: clock low, no frame selected
  initial
  begin
    sclk = 1'b0;
    cs_b = 1'b1;
    mosi = 1'b0;
  end

  // One frame, MSB first; rx is the reply to the previous frame
  task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
    rx = 32'h0;
    @(posedge mclk);
    cs_b <= 1'b0;
    repeat (12) @(posedge mclk);
    // Off-grid start keeps every link edge clear of an mclk edge
    #1.25;
    for (int i = 31; i > 31 - nbits; i--)
    begin
      mosi = tx[i];
      #62.5 sclk = 1'b1;
      // Sample late in the high phase, well after the falling-edge shift
      #62.5 rx[i] = miso;
      sclk = 1'b0;
    end
    #62.5 cs_b = 1'b1;
    // Released data line shows no stale bit
    mosi = ~mosi;
    repeat (12) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// *** testbench/diag_config_and_readback_msgs_tb.sv ***
`default_nettype none
// ********
// Message bench
// ********
module diag_config_and_readback_msgs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, rst_b, sclk, cs_b, mosi, miso, enable_pin, pwm_period_tick;
  logic miso_oe_b, miso_line;
  dcr_pkg::dcr_diag_flags_t [3:0] diag_flags;
  logic [3:0][13:0] current_value;
  logic [3:0] retry_start, retry_expired;
  dcr_pkg::dcr_chan_cfg_t [3:0] chan_cfg;
  logic [31:0] rx;
  int mismatches, checks_done, cycles, n;

  dcr_msg_core i_dcr_msg_core (.mclk(mclk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b),
    .mosi(mosi), .miso(miso), .miso_oe_b(miso_oe_b), .enable_pin(enable_pin),
    .diag_flags(diag_flags), .current_value(current_value),
    .pwm_period_tick(pwm_period_tick), .retry_start(retry_start),
    .retry_expired(retry_expired), .chan_cfg(chan_cfg));

  // Undriven data line reads inverted, so a late or early enable corrupts the reply
  assign miso_line = miso_oe_b ? ~miso : miso;

  dcr_spi_host i_dcr_spi_host (.mclk(mclk), .sclk(sclk), .cs_b(cs_b), .mosi(mosi),
    .miso(miso_line));

  // 100 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic msg(input logic [31:0] tx, input logic [31:0] exp, input string what);
    i_dcr_spi_host.xfer(tx, 32, rx);
    check(what, exp, rx);
  endtask

  // Expected status word from the flags the bench applies
  function automatic logic [31:0] stat(input logic [1:0] lat);
    return {1'b0, 5'h09, diag_flags[0], diag_flags[1], diag_flags[2], diag_flags[3], lat};
  endfunction

  // Retry count in PWM ticks until the channel expires
  task automatic retry(input int ch, input int exp);
    @(posedge mclk);
    retry_start[ch] <= 1'b1;
    @(posedge mclk);
    retry_start[ch] <= 1'b0;
    n = 0;
    repeat (100)
    begin
      @(posedge mclk);
      pwm_period_tick <= 1'b1;
      @(posedge mclk);
      pwm_period_tick <= 1'b0;
      n++;
      // Expiry pulse stands for the one cycle after the counted tick
      #1;
      if (retry_expired[ch] === 1'b1)
        break;
    end
    check("retry ticks", 32'(exp), 32'(n));
  endtask

  task automatic summarize();
    if (mismatches == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Hang guard, well above the expected run length
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      mismatches++;
      summarize();
    end
  end

  // Main sequence
  initial
  begin
    rst_b = 1'b0;
    enable_pin = 1'b1;
    pwm_period_tick = 1'b0;
    retry_start = 4'h0;
    diag_flags = {6'h2a, 6'h15, 6'h33, 6'h0c};
    current_value = {14'h3fff, 14'h2abc, 14'h0001, 14'h1555};
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (6) @(posedge mclk);
    msg(32'h2000_0000, 32'h0, "reset reply");
    msg(32'ha400_0000, 32'h20ff_ffff, "config reset");
    msg(32'haa00_0000, stat(2'b11), "status");
    msg(32'ha012_3450, {8'h2a, 10'h0, 14'h2abc}, "current");
    check("chan cfg", 32'h0012_3450, {8'h0, chan_cfg});
    @(posedge mclk);
    enable_pin <= 1'b0;
    repeat (10) @(posedge mclk);
    msg(32'h2400_0000, 32'h2012_3450, "config rb");
    @(posedge mclk);
    enable_pin <= 1'b1;
    repeat (10) @(posedge mclk);
    msg(32'hfc00_0000, stat(2'b10), "enable latch");
    msg(32'h2400_0000, 32'h7c00_0000, "unknown id");
    msg(32'h2400_0000, stat(2'b10), "latch held");
    msg(32'h2000_0000, stat(2'b00), "latch clear");
    // Short frame carrying an all-zero config write
    i_dcr_spi_host.xfer(32'ha000_0000, 31, rx);
    msg(32'h2000_0000, 32'h2012_3450, "short frame reply");
    msg(32'h2400_0000, 32'h2012_3450, "short frame");
    retry(0, 16);
    retry(2, 4);
    retry(3, 1);
    // Reset in mid-run restores the config and both latches
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (6) @(posedge mclk);
    check("reset cfg", 32'h00ff_ffff, {8'h0, chan_cfg});
    msg(32'h2400_0000, 32'h0, "reset reply 2");
    msg(32'h2000_0000, stat(2'b11), "latch reset");
    msg(32'h2000_0000, 32'h20ff_ffff, "config reset 2");
    summarize();
  end
endmodule
`default_nettype wire
